// *** design/step_sequencer_defs.vh ***
// constants for the eight-output step sequencer
// assumes inclusion by bare name from design files
`ifndef STEP_SEQUENCER_DEFS_VH
`define STEP_SEQUENCER_DEFS_VH
`define SEQ_WIDTH      8
`define SEQ_IDX_W      3
`define SEQ_MIN_TOP    3'h2
`define SEQ_ALL_OFF    8'h00
`define SEQ_OUT0_ONLY  8'h01
`define SEQ_IDX_ZERO   3'h0
`define SEQ_IDX_ONE    3'h1
`define ST_IDLE        1'h0
`define ST_RUN         1'h1
`endif

// *** design/edge_detect.v ***
// rising edge detector for the trigger input
// assumes trigger is synchronous to clock
`timescale 1ns/1ps
module edge_detect (
    input  wire clock,
    input  wire rst,
    input  wire level_in,
    output wire rise
);
    reg level_q;

    always @(posedge clock) begin
        if (rst) begin
            level_q <= 1'b0;
        end else begin
            level_q <= level_in;
        end
    end

    assign rise = level_in & ~level_q;
endmodule

// *** design/step_sequencer.v ***
// eight-output step sequencer: step mode and preset-pattern shift mode
// assumes trigger, enable, reset inputs synchronous to clock
`timescale 1ns/1ps
`include "step_sequencer_defs.vh"

// Function
// - enable low selects step mode and enable high selects preset shift mode.
// - in step mode each trigger rising edge turns on the next selected output from 1 to 7 in order.
// - in step mode the trigger after all selected outputs are on turns off outputs 1 and up, and the cycle restarts.
// - in step mode output 0 is on from the clock after a reset or mode change onward, also during the clearing step.
// - in shift mode each output has a preset bit and the first trigger drives the preset pattern.
// - in shift mode each later trigger shifts the pattern one place up, each output to the next higher one, cyclically.
// - the reset input clears all outputs and returns the sequence to its start.
// - there are eight outputs, 0 to 2 always used and 3 to 7 optional, contiguous from the bottom.
module step_sequencer (
    input  wire                    clock,
    input  wire                    rst,
    input  wire                    enable,
    input  wire                    trigger,
    input  wire                    seq_reset,
    input  wire [`SEQ_IDX_W-1:0]   top_sel,
    input  wire [`SEQ_WIDTH-1:0]   preset,
    output wire [`SEQ_WIDTH-1:0]   outputs
);
    wire                   trig_rise;
    wire [`SEQ_IDX_W-1:0]  top_idx;
    wire [`SEQ_WIDTH-1:0]  sel_mask;
    wire [`SEQ_WIDTH-1:0]  rotated;
    reg  [`SEQ_WIDTH-1:0]  out_q;
    reg  [`SEQ_WIDTH-1:0]  out_d;
    reg  [`SEQ_IDX_W-1:0]  step_q;
    reg  [`SEQ_IDX_W-1:0]  step_d;
    reg                    state_q;
    reg                    state_d;
    reg                    mode_q;

    edge_detect u_trig (
        .clock    (clock),
        .rst      (rst),
        .level_in (trigger),
        .rise     (trig_rise)
    );

    // outputs 0..2 always present, selection contiguous upward
    assign top_idx = (top_sel < `SEQ_MIN_TOP) ? `SEQ_MIN_TOP : top_sel;

    genvar i;
    generate
        for (i = 0; i < `SEQ_WIDTH; i = i + 1) begin : g_bit
            assign sel_mask[i]  = (i <= top_idx);
            // each output takes the next lower one; output 0 takes the top
            if (i == 0) begin : g_wrap
                assign rotated[i] = out_q[top_idx];
            end else begin : g_shift
                assign rotated[i] = sel_mask[i] & out_q[i-1];
            end
        end
    endgenerate

    always @* begin
        out_d   = out_q;
        step_d  = step_q;
        state_d = state_q;
        if (mode_q != enable) begin
            // mode change restarts the sequence
            out_d   = `SEQ_ALL_OFF;
            step_d  = `SEQ_IDX_ZERO;
            state_d = `ST_IDLE;
        end else if (!enable) begin
            out_d[0] = 1'b1;
            if (trig_rise) begin
                // >= also catches a step count left above a lowered selection
                if (step_q >= top_idx) begin
                    out_d  = `SEQ_OUT0_ONLY;
                    step_d = `SEQ_IDX_ZERO;
                end else begin
                    step_d = step_q + `SEQ_IDX_ONE;
                    out_d[step_d] = 1'b1;
                end
            end
        end else if (trig_rise) begin
            case (state_q)
                `ST_IDLE: begin
                    out_d   = preset & sel_mask;
                    state_d = `ST_RUN;
                end
                `ST_RUN: begin
                    out_d = rotated;
                end
                default: begin
                    state_d = `ST_IDLE;
                end
            endcase
        end
        // unselected outputs never reach the register
        out_d = out_d & sel_mask;
    end

    always @(posedge clock) begin
        if (rst || seq_reset) begin
            out_q   <= `SEQ_ALL_OFF;
            step_q  <= `SEQ_IDX_ZERO;
            state_q <= `ST_IDLE;
        end else begin
            out_q   <= out_d;
            step_q  <= step_d;
            state_q <= state_d;
        end
    end

    // follows enable through reset too, so no false mode change follows it
    always @(posedge clock) begin
        mode_q <= enable;
    end

    assign outputs = out_q;
endmodule

// *** testbench/step_sequencer_properties.sv ***
// step_sequencer port assertions
// bound to the dut from tb
`timescale 1ns/1ps
module step_sequencer_properties (
    input wire       clock,
    input wire       rst,
    input wire       enable,
    input wire       trigger,
    input wire       seq_reset,
    input wire [2:0] top_sel,
    input wire [7:0] preset,
    input wire [7:0] outputs
);
    reg q_q = 1'b1, n_q = 1'b1, p_q = 1'b0, e_q = 1'b0;
    wire [2:0] t = top_sel < 3'h2 ? 3'h2 : top_sel;
    wire [7:0] f = ~(8'hfe << t);
    wire c = enable ^ e_q, k = rst | seq_reset | c, r = trigger & ~p_q & ~c, s = ~enable & ~q_q & ~c;
    always @(posedge clock) {q_q, p_q, e_q, n_q} <= {k, trigger, enable, k | n_q & ~(enable & r)};
    default clocking @(posedge clock); endclocking
    default disable iff (rst | seq_reset);
    a_reset_clear: assert property (disable iff (rst) seq_reset |=> outputs == 8'h00) else $error("no clear");
    a_out0_held: assert property (s |-> outputs[0]) else $error("output 0 low");
    a_step_adv: assert property (s && r && outputs != f |=> outputs == {$past(outputs[6:0]), 1'b1})
        else $error("bad step");
    a_step_wrap: assert property (s && r && outputs == f |=> outputs == 8'h01) else $error("bad wrap");
    a_mode_clr: assert property (c |=> outputs == 8'h00) else $error("mode kept");
    a_shift_load: assert property (enable && n_q && r |=> outputs == (preset & f)) else $error("bad load");
    a_shift_rot: assert property (enable && !n_q && r
        |=> outputs == (($past(outputs) << 1 | $past(outputs) >> t) & f)) else $error("bad rotate");
    a_width_mask: assert property ((outputs & ~f) == 8'h00) else $error("unselected on");
endmodule

// *** testbench/trig_src.sv ***
// trigger source standing for the surrounding control logic
// go is set by nonblocking assignment at the falling edge
`timescale 1ns/1ps
module trig_src (
    input  wire clock,
    input  wire go,
    output reg  trigger = 1'b0
);
    always @(negedge clock) trigger <= go;
endmodule

// *** testbench/tb.sv ***
// step_sequencer bench: step, shift and reset scenarios
// trig_src drives trigger; checker bound at the foot
`timescale 1ns/1ps
module tb;
    reg clock = 1'b0, rst = 1'b1, enable = 1'b0, seq_reset = 1'b0, go = 1'b0;
    reg [2:0] top_sel = 3'h3;
    reg [7:0] preset = 8'hc5, e;
    wire trigger;
    wire [7:0] outputs;
    integer n_errors = 0, cmp_count = 0, i;
    always #20 clock = ~clock;
    trig_src src (.clock(clock), .go(go), .trigger(trigger));
    step_sequencer dut (.clock(clock), .rst(rst), .enable(enable), .trigger(trigger),
        .seq_reset(seq_reset), .top_sel(top_sel), .preset(preset), .outputs(outputs));
    task chk(input [7:0] s, x);
        cmp_count = cmp_count + 1;
        if (s !== x) n_errors = n_errors + 1;
        if (s !== x) $display("MISMATCH outputs exp %h seen %h", x, s);
    endtask
    task pulse;
        go <= 1'b1;
        @(negedge clock) go <= 1'b0;
        repeat (2) @(negedge clock);
    endtask
    task t_step;
        for (i = 1; i < 6; i = i + 1) begin
            pulse;
            chk(outputs, i == 4 ? 8'h01 : (8'h01 << (i % 4 + 1)) - 8'h01);
        end
        $display("step test done");
    endtask
    task t_shift;
        {enable, top_sel, e} = {1'b1, 3'h5, 8'h05};
        @(negedge clock) chk(outputs, 8'h00);
        for (i = 0; i < 5; i = i + 1) begin
            pulse;
            chk(outputs, e);
            e = (e << 1 | e >> 5) & 8'h3f;
        end
        $display("shift test done");
    endtask
    task t_reset;
        seq_reset = 1'b1;
        @(negedge clock) seq_reset = 1'b0;
        chk(outputs, 8'h00);
        pulse;
        chk(outputs, 8'h05);
        $display("reset test done");
    endtask
    task t_small;
        {enable, top_sel} = {1'b0, 3'h0};
        @(negedge clock) chk(outputs, 8'h00);
        @(negedge clock) chk(outputs, 8'h01);
        pulse;
        chk(outputs, 8'h03);
        pulse;
        chk(outputs, 8'h07);
        pulse;
        chk(outputs, 8'h01);
        $display("small test done");
    endtask
    task results;
        $display("compares %0d mismatches %0d", cmp_count, n_errors);
        if (n_errors == 0 && cmp_count > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask
    initial begin
        repeat (5) @(negedge clock);
        rst = 1'b0;
        @(negedge clock) chk(outputs, 8'h01);
        t_step;
        t_shift;
        t_reset;
        t_small;
        results;
    end
endmodule
bind step_sequencer step_sequencer_properties props (
    .clock     (clock),
    .rst       (rst),
    .enable    (enable),
    .trigger   (trigger),
    .seq_reset (seq_reset),
    .top_sel   (top_sel),
    .preset    (preset),
    .outputs   (outputs)
);
